// ==== arc_consts.vh ====
// constants for the address and soft reset control register front end
`ifndef ARC_CONSTS_VH
`define ARC_CONSTS_VH

// register offsets
`define ARC_OFS_OWN_ADDR      8'h00
`define ARC_OFS_SOFT_RST      8'h01

// own_slave_address fields
`define ARC_ADDR_MSB          7
`define ARC_ADDR_LSB          1
`define ARC_SRC_BIT           0
`define ARC_SRC_RESET         1'h0

// soft_reset_control fields
`define ARC_RST_VID_BIT       4
`define ARC_RST_FULL_BIT      1
`define ARC_RST_KEEP_BIT      0
`define ARC_RST_REG_RESET     8'h00

// cycles a triggered soft reset stays asserted
`define ARC_RST_CYCLES        5'h10
`define ARC_RST_CNT_ONE       5'h01
`define ARC_RST_CNT_ZERO      5'h00

// byte and bit counting
`define ARC_BITS_PER_BYTE     4'h8
`define ARC_BCNT_ZERO         4'h0
`define ARC_BCNT_ONE          4'h1
`define ARC_PTR_RESET         8'h00
`define ARC_PTR_STEP          8'h01

// strap loads while the count runs, the last load after the synchroniser fills
`define ARC_STRAP_WAIT        2'h3
`define ARC_STRAP_ONE         2'h1
`define ARC_STRAP_ZERO        2'h0

// address chosen by each strap level
`define ARC_STRAP_ADDR_0      7'h0C
`define ARC_STRAP_ADDR_1      7'h0E
`define ARC_STRAP_ADDR_2      7'h10
`define ARC_STRAP_ADDR_3      7'h12
`define ARC_STRAP_ADDR_4      7'h14
`define ARC_STRAP_ADDR_5      7'h16
`define ARC_STRAP_ADDR_6      7'h18
`define ARC_STRAP_ADDR_7      7'h1A

`endif

// ==== arc_sync.v ====
// two flip-flop synchroniser, one per bit
module arc_sync #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;

genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
		always @(posedge ref_clk) begin
			if (sys_rst) begin
				stage1[i] <= 1'b1;
				stage2[i] <= 1'b1;
			end else begin
				stage1[i] <= din[i];
				stage2[i] <= stage1[i];
			end
		end
	end
endgenerate

assign dout = stage2;

endmodule

// ==== arc_regs.v ====
// control bus slave with own address and soft reset registers
//
// How it works
// - address field in bits 7:1, strap loaded
// - bit 0 chooses strap or written address
// - bit 4 pulses video-input reset, self-clears
// - bit 1 resets whole core including registers
// - bit 0 resets core, own address register restored, self-clears
// - preserving reset reloads strap-loaded values
// - preserving reset restores listed registers to defaults
// - soft reset honoured only at 3.3V level
// - acknowledge only own active address
`include "arc_consts.vh"

module arc_regs (
	input  wire       ref_clk,
	input  wire       sys_rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire [2:0] address_strap_input,
	input  wire       bus_level_3v3,
	output reg        video_input_reset,
	output reg        full_core_reset,
	output reg        register_preserving_core_reset
);

localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_ADDR  = 3'h1;
localparam [2:0] ST_AACK  = 3'h2;
localparam [2:0] ST_WPTR  = 3'h3;
localparam [2:0] ST_WACK  = 3'h4;
localparam [2:0] ST_WDATA = 3'h5;
localparam [2:0] ST_RDATA = 3'h6;
localparam [2:0] ST_RACK  = 3'h7;

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [5:0] sync_out;
wire       scl_s;
wire       sda_s;
wire [2:0] strap_s;
wire       lvl_s;

arc_sync #(
	.WIDTH (6)
) u_sync (
	.ref_clk (ref_clk),
	.sys_rst (sys_rst),
	.din     ({scl_in, sda_in, address_strap_input, bus_level_3v3}),
	.dout    (sync_out)
);

assign scl_s   = sync_out[5];
assign sda_s   = sync_out[4];
assign strap_s = sync_out[3:1];
assign lvl_s   = sync_out[0];

reg scl_q;
reg sda_q;

always @(posedge ref_clk) begin
	if (sys_rst) begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
	end else begin
		scl_q <= scl_s;
		sda_q <= sda_s;
	end
end

wire scl_rise = scl_s & ~scl_q;
wire scl_fall = ~scl_s & scl_q;
wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

////////////////////////////////////////////////////////////////////////////////
// strap decode

reg [6:0] strap_addr_dec;

always @* begin
	case (strap_s)
	3'h0:    strap_addr_dec = `ARC_STRAP_ADDR_0;
	3'h1:    strap_addr_dec = `ARC_STRAP_ADDR_1;
	3'h2:    strap_addr_dec = `ARC_STRAP_ADDR_2;
	3'h3:    strap_addr_dec = `ARC_STRAP_ADDR_3;
	3'h4:    strap_addr_dec = `ARC_STRAP_ADDR_4;
	3'h5:    strap_addr_dec = `ARC_STRAP_ADDR_5;
	3'h6:    strap_addr_dec = `ARC_STRAP_ADDR_6;
	default: strap_addr_dec = `ARC_STRAP_ADDR_7;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// registers and soft reset sequencing

reg [6:0] strap_addr;
reg [1:0] strap_cnt;
reg [6:0] own_address_field;
reg       address_source_select;
reg [4:0] rst_cnt;
reg [7:0] ptr;
reg [7:0] sr;
reg [3:0] bcnt;
reg [2:0] state;
reg       rw;

wire [6:0] active_addr = address_source_select ? own_address_field : strap_addr;
wire       wr_strobe   = (state == ST_WDATA) & scl_fall & (bcnt == `ARC_BITS_PER_BYTE);
wire       rst_write   = wr_strobe & (ptr == `ARC_OFS_SOFT_RST) & lvl_s;
wire       rst_done    = (rst_cnt == `ARC_RST_CNT_ONE);
wire       regs_restore = rst_done & (full_core_reset | register_preserving_core_reset);
wire       strap_load   = (strap_cnt != `ARC_STRAP_ZERO);

reg [7:0] rd_byte;

always @* begin
	case (ptr)
	`ARC_OFS_OWN_ADDR: rd_byte = {own_address_field, address_source_select};
	`ARC_OFS_SOFT_RST: rd_byte = {3'h0, video_input_reset, 2'h0, full_core_reset,
		register_preserving_core_reset};
	default:           rd_byte = 8'h00;
	endcase
end

// syncs hold ones in reset, so keep loading until the strap has arrived
always @(posedge ref_clk) begin
	if (sys_rst) begin
		strap_cnt  <= `ARC_STRAP_WAIT;
		strap_addr <= `ARC_STRAP_ADDR_0;
	end else if (strap_load) begin
		strap_cnt  <= strap_cnt - `ARC_STRAP_ONE;
		strap_addr <= strap_addr_dec;
	end else if (regs_restore) begin
		strap_cnt  <= `ARC_STRAP_ONE;
	end
end

always @(posedge ref_clk) begin
	if (sys_rst) begin
		own_address_field     <= `ARC_STRAP_ADDR_0;
		address_source_select <= `ARC_SRC_RESET;
	end else if (strap_load) begin
		own_address_field     <= strap_addr_dec;
	end else if (regs_restore) begin
		address_source_select <= `ARC_SRC_RESET;
	end else if (wr_strobe && ptr == `ARC_OFS_OWN_ADDR) begin
		own_address_field     <= sr[`ARC_ADDR_MSB:`ARC_ADDR_LSB];
		address_source_select <= sr[`ARC_SRC_BIT];
	end
end

always @(posedge ref_clk) begin
	if (sys_rst) begin
		video_input_reset              <= 1'b0;
		full_core_reset                <= 1'b0;
		register_preserving_core_reset <= 1'b0;
		rst_cnt                        <= `ARC_RST_CNT_ZERO;
	end else if (rst_write && (sr[`ARC_RST_VID_BIT] | sr[`ARC_RST_FULL_BIT]
		| sr[`ARC_RST_KEEP_BIT])) begin
		video_input_reset              <= video_input_reset | sr[`ARC_RST_VID_BIT];
		full_core_reset                <= full_core_reset | sr[`ARC_RST_FULL_BIT];
		register_preserving_core_reset <= register_preserving_core_reset
			| sr[`ARC_RST_KEEP_BIT];
		rst_cnt                        <= `ARC_RST_CYCLES;
	end else if (rst_done) begin
		video_input_reset              <= 1'b0;
		full_core_reset                <= 1'b0;
		register_preserving_core_reset <= 1'b0;
		rst_cnt                        <= `ARC_RST_CNT_ZERO;
	end else if (rst_cnt != `ARC_RST_CNT_ZERO) begin
		rst_cnt <= rst_cnt - `ARC_RST_CNT_ONE;
	end
end

////////////////////////////////////////////////////////////////////////////////
// control bus slave

always @(posedge ref_clk) begin
	if (sys_rst) begin
		state   <= ST_IDLE;
		sr      <= 8'h00;
		bcnt    <= `ARC_BCNT_ZERO;
		rw      <= 1'b0;
		ptr     <= `ARC_PTR_RESET;
		sda_oe  <= 1'b0;
		sda_out <= 1'b0;
	end else if (bus_start) begin
		state  <= ST_ADDR;
		bcnt   <= `ARC_BCNT_ZERO;
		sda_oe <= 1'b0;
	end else if (bus_stop) begin
		state  <= ST_IDLE;
		sda_oe <= 1'b0;
	end else if (scl_rise) begin
		case (state)
		ST_ADDR, ST_WPTR, ST_WDATA: begin
			sr   <= {sr[6:0], sda_s};
			bcnt <= bcnt + `ARC_BCNT_ONE;
		end
		ST_RDATA: begin
			sr   <= {sr[6:0], 1'b0};
			bcnt <= bcnt + `ARC_BCNT_ONE;
		end
		ST_RACK: begin
			if (!sda_s) begin
				ptr   <= ptr + `ARC_PTR_STEP;
				state <= ST_AACK;
				rw    <= 1'b1;
			end else begin
				state <= ST_IDLE;
			end
		end
		default: begin
			state <= state;
		end
		endcase
	end else if (scl_fall) begin
		case (state)
		ST_ADDR: begin
			if (bcnt == `ARC_BITS_PER_BYTE) begin
				if (sr[7:1] == active_addr) begin
					sda_oe <= 1'b1;
					rw     <= sr[0];
					state  <= ST_AACK;
				end else begin
					state  <= ST_IDLE;
				end
			end
		end
		ST_AACK: begin
			bcnt <= `ARC_BCNT_ZERO;
			if (rw) begin
				sr     <= rd_byte;
				sda_oe <= ~rd_byte[7];
				state  <= ST_RDATA;
			end else begin
				sda_oe <= 1'b0;
				state  <= ST_WPTR;
			end
		end
		ST_WPTR, ST_WDATA: begin
			if (bcnt == `ARC_BITS_PER_BYTE) begin
				if (state == ST_WPTR) begin
					ptr <= sr;
				end
				sda_oe <= 1'b1;
				state  <= ST_WACK;
			end
		end
		ST_WACK: begin
			sda_oe <= 1'b0;
			bcnt   <= `ARC_BCNT_ZERO;
			state  <= ST_WDATA;
		end
		ST_RDATA: begin
			if (bcnt == `ARC_BITS_PER_BYTE) begin
				sda_oe <= 1'b0;
				state  <= ST_RACK;
			end else begin
				sda_oe <= ~sr[7];
			end
		end
		default: begin
			sda_oe <= 1'b0;
		end
		endcase
		if (wr_strobe) begin
			ptr <= ptr + `ARC_PTR_STEP;
		end
	end
end

endmodule

// ==== arc_props.sv ====
// concurrent checks on the control register front end ports
`include "arc_consts.vh"
module arc_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic bus_level_3v3,
	input wire logic video_input_reset,
	input wire logic full_core_reset,
	input wire logic register_preserving_core_reset
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	logic [4:0] rv;
	logic [4:0] rf;
	logic [4:0] rk;
	// length of the current high run of each reset output
	always @(posedge ref_clk) begin
		rv <= (sys_rst || !video_input_reset) ? 5'h00 : rv + 5'h01;
		rf <= (sys_rst || !full_core_reset) ? 5'h00 : rf + 5'h01;
		rk <= (sys_rst || !register_preserving_core_reset) ? 5'h00 : rk + 5'h01;
	end
	odrain_low_a: assert property (sda_out == 1'b0)
		else $error("data output not low");
	oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in && $past(scl_in, 2) == 1'b0)
		else $error("data enable moved outside clock low");
	vid_width_a: assert property ($fell(video_input_reset) |-> rv == `ARC_RST_CYCLES)
		else $error("video reset width wrong");
	full_width_a: assert property ($fell(full_core_reset) |-> rf == `ARC_RST_CYCLES)
		else $error("full reset width wrong");
	keep_width_a: assert property ($fell(register_preserving_core_reset) |-> rk == `ARC_RST_CYCLES)
		else $error("preserving reset width wrong");
	vid_level_a: assert property ($rose(video_input_reset) |-> bus_level_3v3 && !scl_in)
		else $error("video reset without bus level");
	full_level_a: assert property ($rose(full_core_reset) |-> bus_level_3v3 && !scl_in)
		else $error("full reset without bus level");
	keep_level_a: assert property ($rose(register_preserving_core_reset) |-> bus_level_3v3)
		else $error("preserving reset without bus level");
	cover property ($rose(video_input_reset));
	cover property ($rose(full_core_reset));
	cover property ($rose(register_preserving_core_reset));
endmodule
bind arc_regs arc_props i_props (.ref_clk, .sys_rst, .scl_in, .sda_out, .sda_oe, .bus_level_3v3,
	.video_input_reset, .full_core_reset, .register_preserving_core_reset);

// ==== arc_host.sv ====
// control bus host model, open drain with pull-up on the data line
module arc_host (
	input  wire  ref_clk,
	input  wire  sda_in,
	output logic scl_in,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_in = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// data changes only while the clock is low
	task automatic bitx(input logic b, output logic r);
		sda_low <= ~b;
		tick(6);
		scl_in <= 1'b1;
		tick(6);
		r = sda_in;
		scl_in <= 1'b0;
		tick(2);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		tick(6);
		scl_in <= 1'b1;
		tick(6);
		sda_low <= 1'b1;
		tick(6);
		scl_in <= 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(6);
		scl_in <= 1'b1;
		tick(6);
		sda_low <= 1'b0;
		tick(6);
	endtask
	// msb first byte then acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ab, a);
	endtask
endmodule

// ==== tb_arc_regs.sv ====
// self-checking bench for the control register front end
`include "arc_consts.vh"
module tb_arc_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk;
	logic       sys_rst;
	logic [2:0] address_strap_input;
	logic       bus_level_3v3;
	wire        scl_in;
	wire        sda_low;
	wire        sda_out;
	wire        sda_oe;
	wire        video_input_reset;
	wire        full_core_reset;
	wire        register_preserving_core_reset;
	wire        sda_in = ~(sda_low | (sda_oe & ~sda_out));
	int         errors;
	int         n_tests;
	logic [7:0] hi [3] = '{8'h00, 8'h00, 8'h00};
	logic [6:0] cur;
	logic [6:0] strap;
	logic [7:0] q;
	logic       a;
	arc_host i_host (.ref_clk, .sda_in, .scl_in, .sda_low);
	arc_regs i_dut (.ref_clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .address_strap_input,
		.bus_level_3v3, .video_input_reset, .full_core_reset, .register_preserving_core_reset);
	// running count of high cycles on each reset output
	always @(posedge ref_clk) begin
		if (!sys_rst) begin
			hi[0] <= hi[0] + {7'h00, video_input_reset};
			hi[1] <= hi[1] + {7'h00, full_core_reset};
			hi[2] <= hi[2] + {7'h00, register_preserving_core_reset};
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	function automatic logic [6:0] strap_addr(input logic [2:0] s);
		return 7'h0c + {3'h0, s, 1'b0};
	endfunction
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d, output logic ak);
		i_host.start();
		i_host.xfer({ad, 1'b0}, 1'b1, q, a);
		ak = ~a;
		if (ak) begin
			i_host.xfer(p, 1'b1, q, a);
			i_host.xfer(d, 1'b1, q, a);
		end
		i_host.stop();
	endtask
	// pointer write then repeated start read, master ends with not-acknowledge
	task automatic rd(input logic [6:0] ad, input logic [7:0] p, output logic [7:0] d);
		i_host.start();
		i_host.xfer({ad, 1'b0}, 1'b1, q, a);
		i_host.xfer(p, 1'b1, q, a);
		i_host.start();
		i_host.xfer({ad, 1'b1}, 1'b1, q, a);
		i_host.xfer(8'hff, 1'b1, d, a);
		i_host.stop();
	endtask
	initial begin
		int bt [4] = '{4, 4, 1, 0};
		int ix [4] = '{0, 0, 1, 2};
		logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
		logic       ak;
		logic [7:0] d;
		logic [6:0] na;
		void'($urandom(32'h0000_3667));
		sys_rst <= 1'b1;
		bus_level_3v3 <= 1'b0;
		address_strap_input <= 3'($urandom);
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		strap = strap_addr(address_strap_input);
		cur = strap;
		repeat (6) @(posedge ref_clk);
		rd(strap, 8'h00, d);
		check("own address", d, {strap, 1'b0});
		wr(strap ^ 7'h01, 8'h00, 8'h00, ak);
		check("foreign ack", 8'(ak), 8'h00);
		for (int k = 0; k < 4; k++) begin
			bus_level_3v3 <= (k != 0);
			na = 7'h40 | 7'($urandom);
			wr(cur, 8'h00, {na, 1'b1}, ak);
			cur = na;
			wr(strap, 8'h00, 8'h00, ak);
			check("strap ack", 8'(ak), 8'h00);
			wr(cur, 8'h01, 8'he0 | (8'h01 << bt[k]), ak);
			if (k != 0) ev[ix[k]] += {3'h0, `ARC_RST_CYCLES};
			if (k > 1) cur = strap;
			if (k == 2) begin
				wr(cur, 8'h4f, 8'h02, ak);
				check("bridge ack", 8'(ak), 8'h01);
			end
			rd(cur, 8'h00, d);
			check("own address", d, {cur, cur != strap});
			rd(cur, 8'h01, d);
			check("reset reg", d, 8'h00);
			for (int j = 0; j < 3; j++) check("pulse count", hi[j], ev[j]);
		end
		end_sim();
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		end_sim();
	end
endmodule
